/* File: core/rst_sequencer.sv */
// reset sequencer with watchdog and apb register slave
//
// The APB register port and the register addresses were left to the implementer.
`timescale 1ns/1ns
`default_nettype none

module rst_sequencer
    import rstseq_pkg::*;
(
    input  wire logic        clk,                     // system clock, 50 MHz
    input  wire logic        nrst,                    // power-on reset, active low
    input  wire logic        psel,                    // apb select
    input  wire logic        penable,                 // apb enable
    input  wire logic        pwrite,                  // apb direction
    input  wire logic [11:0] paddr,                   // apb byte address
    input  wire logic [31:0] pwdata,                  // apb write data
    output logic      [31:0] prdata,                  // apb read data
    output logic             pready,                  // apb ready
    output logic             pslverr,                 // apb error, unmapped address
    input  wire logic        clear_pin_n,             // external clear pin, active low
    input  wire logic        wdog_clk_in,             // 1 kHz watchdog clock
    input  wire logic        low_voltage_in,          // supply below detect level
    input  wire logic        illegal_address_detect,  // core pulse
    input  wire logic        illegal_opcode_detect,   // core pulse
    input  wire logic        debug_controller_reset,  // debug reset command pulse
    input  wire logic        in_debug,                // background debug mode
    input  wire logic        in_stop,                 // stop mode
    output logic             sys_rst_n,               // system reset, active low
    output logic             sysclk_src_en,           // system clock source enable
    output logic             bus_clk,                 // bus clock, half rate
    output logic             bus_clk_run              // bus clock running
);
    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    seq_state_e state_q;
    logic [6:0] bus_cnt_q;
    logic [6:0] exit_cnt_q;
    logic [4:0] sys_cnt_q;
    logic       pin_kind_q;
    logic       bus_phase_q;
    logic       bus_edge;
    logic       rst_active;
    logic       pin_low_raw;
    logic [2:0] sync_out;
    logic       pin_low_s;
    logic       wclk_s;
    logic       wdog_ovf_s;
    logic       wclk_prev_q;
    logic       wdog_tick;
    logic [8:0] wdog_cnt_q;
    logic [8:0] wdog_limit;
    logic       wdog_ovf_q;
    logic [2:0] opt_q;
    logic       locked_q;
    logic [4:0] cause_q;
    logic [2:0] sync_pend_q;
    logic       sync_req;
    logic       lv_q;
    logic       wr_access;
    logic       wr_options;
    logic       wr_status;
    logic       rd_setup;

    // ------------------------------------------------------------
    // decode helper
    // ------------------------------------------------------------
    function automatic logic addr_mapped(input logic [11:0] a);
        return (a == ADDR_SYSTEM_OPTIONS) || (a == ADDR_RESET_STATUS) ||
               (a == ADDR_POWER_MGMT);
    endfunction

    // ------------------------------------------------------------
    // pin qualification and immediate reset
    // ------------------------------------------------------------
    assign pin_low_raw = !clear_pin_n && opt_q[OPT_PIN_EN_BIT];
    assign rst_active  = (state_q != ST_RUN);
    assign sys_rst_n   = !(rst_active || pin_low_raw);

    // synchronise pin, watchdog clock and overflow
    sync2 #(.W(3)) u_sync (
        .clk  (clk),
        .nrst (nrst),
        .d    ({wdog_ovf_q, wdog_clk_in, pin_low_raw}),
        .q    (sync_out)
    );
    assign pin_low_s  = sync_out[0];
    assign wclk_s     = sync_out[1];
    assign wdog_ovf_s = sync_out[2];

    // ------------------------------------------------------------
    // bus clock divider
    // ------------------------------------------------------------
    assign bus_clk_run   = (state_q != ST_HOLD) && (state_q != ST_RESTART);
    assign sysclk_src_en = (state_q != ST_HOLD);
    assign bus_clk       = bus_phase_q && bus_clk_run;  // held low while stopped
    assign bus_edge      = bus_clk_run && !bus_phase_q;

    // toggle every system cycle while the bus clock runs
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            bus_phase_q <= 1'b0;
        end else if (bus_clk_run) begin
            bus_phase_q <= !bus_phase_q;
        end else begin
            bus_phase_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // synchronous reset requests
    // ------------------------------------------------------------
    assign sync_req = |sync_pend_q;

    // pending requests, dropped while reset is asserted
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sync_pend_q <= 3'h0;
        end else if (rst_active) begin
            sync_pend_q <= 3'h0;
        end else begin
            sync_pend_q <= sync_pend_q | {debug_controller_reset,
                                          illegal_opcode_detect,
                                          illegal_address_detect};
        end
    end

    // ------------------------------------------------------------
    // reset exit sequencer
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_q    <= ST_RUN;
            bus_cnt_q  <= 7'h00;
            exit_cnt_q <= BUS_ASYNC_EXIT;
            sys_cnt_q  <= 5'h00;
            pin_kind_q <= 1'b0;
        end else begin
            unique case (state_q)
                ST_RUN: begin
                    bus_cnt_q <= 7'h00;
                    if (pin_low_s || wdog_ovf_s) begin
                        state_q    <= ST_COUNT;
                        exit_cnt_q <= BUS_ASYNC_EXIT;
                        pin_kind_q <= pin_low_s;
                    end else if (sync_req) begin
                        state_q    <= ST_COUNT;
                        exit_cnt_q <= BUS_SYNC_EXIT;
                        pin_kind_q <= 1'b0;
                    end
                end
                ST_COUNT: begin
                    if (pin_low_s && !pin_kind_q) begin
                        bus_cnt_q  <= 7'h00;
                        exit_cnt_q <= BUS_ASYNC_EXIT;
                        pin_kind_q <= 1'b1;
                    end else if (bus_edge) begin
                        if (pin_kind_q && pin_low_s && bus_cnt_q == BUS_PIN_CHECK - 7'h01) begin
                            state_q <= ST_HOLD;
                        end else if (bus_cnt_q == exit_cnt_q - 7'h01) begin
                            state_q <= ST_RUN;
                        end
                        bus_cnt_q <= bus_cnt_q + 7'h01;
                    end
                end
                ST_HOLD: begin
                    sys_cnt_q <= 5'h00;
                    if (!pin_low_s) begin
                        state_q <= ST_RESTART;
                    end
                end
                ST_RESTART: begin
                    if (pin_low_s) begin
                        state_q <= ST_HOLD;
                    end else if (sys_cnt_q == SYS_RESTART - 5'h01) begin
                        state_q   <= ST_FINAL;
                        bus_cnt_q <= 7'h00;
                    end
                    sys_cnt_q <= sys_cnt_q + 5'h01;
                end
                ST_FINAL: begin
                    if (pin_low_s) begin
                        state_q    <= ST_COUNT;
                        bus_cnt_q  <= 7'h00;
                        exit_cnt_q <= BUS_ASYNC_EXIT;
                    end else if (bus_edge) begin
                        if (bus_cnt_q == BUS_FINAL_EDGES - 7'h01) begin
                            state_q <= ST_RUN;
                        end
                        bus_cnt_q <= bus_cnt_q + 7'h01;
                    end
                end
                default: begin
                    state_q <= ST_COUNT;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // reset cause capture
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cause_q <= CAUSE_RESET;
        end else if (state_q == ST_RUN && (pin_low_s || wdog_ovf_s || sync_req)) begin
            cause_q <= {sync_pend_q[2], sync_pend_q[1], sync_pend_q[0],
                        wdog_ovf_s && !pin_low_s, pin_low_s};
        end else if (state_q == ST_COUNT && pin_low_s && !pin_kind_q) begin
            cause_q <= 5'h01;
        end
    end

    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------
    assign pready     = 1'b1;
    assign pslverr    = psel && penable && !addr_mapped(paddr);
    assign wr_access  = psel && penable && pwrite && !rst_active;
    assign wr_options = wr_access && (paddr == ADDR_SYSTEM_OPTIONS);
    assign wr_status  = wr_access && (paddr == ADDR_RESET_STATUS);
    assign rd_setup   = psel && !penable && !pwrite;

    // ------------------------------------------------------------
    // system options register with watchdog lock
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            opt_q    <= OPT_RESET;
            locked_q <= 1'b0;
        end else if (rst_active) begin
            opt_q    <= OPT_RESET;
            locked_q <= 1'b0;
        end else if (wr_options) begin
            opt_q[OPT_PIN_EN_BIT] <= pwdata[OPT_PIN_EN_BIT];
            if (!locked_q) begin
                opt_q[OPT_WDOG_EN_BIT]  <= pwdata[OPT_WDOG_EN_BIT];
                opt_q[OPT_WDOG_SEL_BIT] <= pwdata[OPT_WDOG_SEL_BIT];
                locked_q                <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // watchdog counter on the 1 kHz clock edges
    // ------------------------------------------------------------
    assign wdog_tick  = wclk_s && !wclk_prev_q;
    assign wdog_limit = opt_q[OPT_WDOG_SEL_BIT] ? WDOG_LONG_CNT : WDOG_SHORT_CNT;

    // previous synchronised watchdog clock level
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wclk_prev_q <= 1'b0;
        end else begin
            wclk_prev_q <= wclk_s;
        end
    end

    // count, clear and overflow
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wdog_cnt_q <= 9'h000;
            wdog_ovf_q <= 1'b0;
        end else if (rst_active || !sys_rst_n) begin
            wdog_cnt_q <= 9'h000;
            wdog_ovf_q <= 1'b0;
        end else if (in_stop) begin
            wdog_cnt_q <= 9'h000;
        end else if (wr_status || (wr_options && !locked_q)) begin
            wdog_cnt_q <= 9'h000;
        end else if (opt_q[OPT_WDOG_EN_BIT] && wdog_tick && !in_debug) begin
            if (wdog_cnt_q == wdog_limit - 9'h001) begin
                wdog_ovf_q <= 1'b1;
                wdog_cnt_q <= 9'h000;
            end else begin
                wdog_cnt_q <= wdog_cnt_q + 9'h001;
            end
        end
    end

    // ------------------------------------------------------------
    // low voltage flag
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            lv_q <= 1'b0;
        end else begin
            lv_q <= low_voltage_in;
        end
    end

    // ------------------------------------------------------------
    // apb read data, captured in the setup cycle
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            prdata <= 32'h0000_0000;
        end else if (rd_setup) begin
            prdata <= 32'h0000_0000;
            unique case (paddr)
                ADDR_SYSTEM_OPTIONS: begin
                    prdata[2:0]            <= opt_q;
                    prdata[OPT_LOCKED_BIT] <= locked_q;
                end
                ADDR_RESET_STATUS: begin
                    prdata[4:0]  <= cause_q;
                    prdata[16:8] <= wdog_cnt_q;
                end
                ADDR_POWER_MGMT: begin
                    prdata[PWR_LV_FLAG_BIT] <= lv_q;
                end
                default: begin
                    prdata <= 32'h0000_0000;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

/* File: core/rstseq_pkg.sv */
// constants and types shared by the reset sequencer design files
package rstseq_pkg;

    // ------------------------------------------------------------
    // register map (byte addresses on apb)
    // ------------------------------------------------------------
    localparam logic [11:0] ADDR_SYSTEM_OPTIONS = 12'h000;
    localparam logic [11:0] ADDR_RESET_STATUS   = 12'h004;
    localparam logic [11:0] ADDR_POWER_MGMT     = 12'h008;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int OPT_PIN_EN_BIT   = 0;  // clear_pin_enable
    localparam int OPT_WDOG_EN_BIT  = 1;  // watchdog_enable
    localparam int OPT_WDOG_SEL_BIT = 2;  // watchdog_timeout_select
    localparam int OPT_LOCKED_BIT   = 7;  // read only: watchdog settings locked
    localparam int CAUSE_PIN_BIT    = 0;
    localparam int CAUSE_WDOG_BIT   = 1;
    localparam int CAUSE_ILL_ADDR   = 2;
    localparam int CAUSE_ILL_OP     = 3;
    localparam int CAUSE_DEBUG      = 4;
    localparam int PWR_LV_FLAG_BIT  = 0;  // low_voltage_flag

    // ------------------------------------------------------------
    // values after reset
    // ------------------------------------------------------------
    localparam logic [2:0] OPT_RESET   = 3'h7;  // pin on, watchdog on, long timeout
    localparam logic [4:0] CAUSE_RESET = 5'h00;

    // ------------------------------------------------------------
    // reset exit timing, in bus or system clock cycles
    // ------------------------------------------------------------
    localparam logic [6:0] BUS_ASYNC_EXIT  = 7'h4A;  // 74 bus cycles
    localparam logic [6:0] BUS_PIN_CHECK   = 7'h45;  // 69 bus cycles
    localparam logic [6:0] BUS_SYNC_EXIT   = 7'h47;  // 71 bus cycles
    localparam logic [6:0] BUS_FINAL_EDGES = 7'h05;  // fifth bus edge
    localparam logic [4:0] SYS_RESTART     = 5'h12;  // 18 system cycles

    // ------------------------------------------------------------
    // watchdog timing: 1 kHz tick, overflow times in ms
    // ------------------------------------------------------------
    localparam int WDOG_TICK_HZ  = 1000;
    localparam int WDOG_SHORT_MS = 32;
    localparam int WDOG_LONG_MS  = 256;
    localparam logic [8:0] WDOG_SHORT_CNT = 9'(WDOG_SHORT_MS * WDOG_TICK_HZ / 1000);
    localparam logic [8:0] WDOG_LONG_CNT  = 9'(WDOG_LONG_MS * WDOG_TICK_HZ / 1000);

    // ------------------------------------------------------------
    // sequencer states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_RUN,      // out of reset
        ST_COUNT,    // reset asserted, counting bus cycles
        ST_HOLD,     // long pin pulse, clock source stopped
        ST_RESTART,  // pin released, waiting for bus clock
        ST_FINAL     // bus clock back, counting last edges
    } seq_state_e;

endpackage

/* File: core/sync2.sv */
// two flip-flop level synchroniser, one per bit
`timescale 1ns/1ns
`default_nettype none
module sync2 #(
    parameter int W = 1
) (
    input  wire logic         clk,     // system clock
    input  wire logic         nrst,    // async reset, active low
    input  wire logic [W-1:0] d,       // asynchronous levels
    output logic      [W-1:0] q        // synchronised levels
);
    logic [W-1:0] meta_q;

    // ------------------------------------------------------------
    // two stages per bit
    // ------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            always_ff @(posedge clk or negedge nrst) begin
                if (!nrst) begin
                    meta_q[i] <= 1'b0;
                    q[i]      <= 1'b0;
                end else begin
                    meta_q[i] <= d[i];
                    q[i]      <= meta_q[i];
                end
            end
        end
    endgenerate
endmodule
`default_nettype wire

/* File: core/rst_sequencer_end.sv */
// holds no logic, kept empty on purpose

/* File: verification/rst_partner.sv */
// model of the external clear driver and the watchdog tick source
`timescale 1ns/1ns
`default_nettype none
module rst_partner (
    input  wire logic clk,         // system clock
    output logic      clear_pin_n, // clear pin, pulled up when released
    output logic      wdog_clk_in  // watchdog tick clock
);
    // the pad pull-up holds the pin high, the tick clock rests low
    initial clear_pin_n = 1'b1;
    initial wdog_clk_in = 1'b0;
    // drive the pin low for n system cycles, then let the pull-up win
    task automatic pin_low(input int n);
        @(posedge clk);
        clear_pin_n <= 1'b0;
        repeat (n) @(posedge clk);
        clear_pin_n <= 1'b1;
    endtask
    // n tick periods of eight system cycles, sped up for simulation
    task automatic ticks(input int n);
        repeat (n) begin
            repeat (4) @(posedge clk);
            wdog_clk_in <= 1'b1;
            repeat (4) @(posedge clk);
            wdog_clk_in <= 1'b0;
        end
    endtask
endmodule
`default_nettype wire

/* File: verification/rst_sequencer_asserts.sv */
// port-level assertions for the reset sequencer
`timescale 1ns/1ns
`default_nettype none
module rst_sequencer_asserts import rstseq_pkg::*; (
    input wire logic        clk,                   // system clock
    input wire logic        nrst,                  // async reset
    input wire logic        psel,                  // apb select
    input wire logic        penable,               // apb enable
    input wire logic        pwrite,                // apb direction
    input wire logic [11:0] paddr,                 // apb address
    input wire logic [31:0] prdata,                // apb read data
    input wire logic        clear_pin_n,           // clear pin
    input wire logic        low_voltage_in,        // supply falling
    input wire logic        illegal_opcode_detect, // sync source
    input wire logic        sys_rst_n,             // system reset
    input wire logic        sysclk_src_en,         // clock source enable
    input wire logic        bus_clk,               // bus clock
    input wire logic        bus_clk_run            // bus clock running
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    logic [8:0] low_q; // cycles spent in system reset
    // saturating count of reset cycles, cleared once reset ends
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) low_q <= 9'h000;
        else if (sys_rst_n) low_q <= 9'h000;
        else if (low_q != 9'h1FF) low_q <= low_q + 9'h001;
    end
    a_hold_stops_bus: assert property (!sysclk_src_en |-> !sys_rst_n && !bus_clk_run)
        else $error("clock source stopped outside reset");
    a_bus_idle_low: assert property (!bus_clk_run |-> !sys_rst_n && !bus_clk)
        else $error("bus clock stopped outside reset");
    a_bus_half: assert property ($past(nrst) && bus_clk_run && $past(bus_clk_run)
        |-> bus_clk != $past(bus_clk)) else $error("bus clock not at half rate");
    a_sync_prompt: assert property ($rose(illegal_opcode_detect) && sys_rst_n && clear_pin_n
        |-> ##[1:2] !sys_rst_n) else $error("sync source did not start reset");
    a_min_reset: assert property ($rose(sys_rst_n) |-> low_q >= 9'h08C)
        else $error("system reset released too early");
    a_restart_wait: assert property ($rose(sysclk_src_en)
        |-> !bus_clk_run [*8] ##[1:14] bus_clk_run) else $error("bus clock restart late");
    a_final_exit: assert property ($rose(bus_clk_run) |-> ##[1:11] sys_rst_n)
        else $error("reset not left after restart");
    a_low_volt: assert property (psel && penable && !pwrite && paddr == ADDR_POWER_MGMT
        |-> prdata[PWR_LV_FLAG_BIT] == $past(low_voltage_in, 2)) else $error("flag wrong");
endmodule
bind rst_sequencer rst_sequencer_asserts u_rst_sequencer_asserts (.clk, .nrst, .psel,
    .penable, .pwrite, .paddr, .prdata, .clear_pin_n, .low_voltage_in,
    .illegal_opcode_detect, .sys_rst_n, .sysclk_src_en, .bus_clk, .bus_clk_run);
`default_nettype wire

/* File: verification/rst_sequencer_tb.sv */
// self-checking testbench for the reset sequencer
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin num_errors++; \
    $display("[ERR] %0t got %0h exp %0h", $time, (g), (e)); end end
module rst_sequencer_tb import rstseq_pkg::*;;
    logic        clk, nrst, psel, penable, pwrite, pready, pslverr, err;
    logic        low_voltage_in, in_debug, in_stop, clear_pin_n, wdog_clk_in;
    logic        illegal_address_detect, illegal_opcode_detect, debug_controller_reset;
    logic        sys_rst_n, sysclk_src_en, bus_clk, bus_clk_run;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    int          num_errors, n_checks, n;
    // design and far-side model
    rst_sequencer u_rst_sequencer (.clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .clear_pin_n, .wdog_clk_in, .low_voltage_in,
        .illegal_address_detect, .illegal_opcode_detect, .debug_controller_reset,
        .in_debug, .in_stop, .sys_rst_n, .sysclk_src_en, .bus_clk, .bus_clk_run);
    rst_partner u_rst_partner (.clk, .clear_pin_n, .wdog_clk_in);
    // 50 MHz system clock
    always #10 clk = ~clk;
    // verdict and end of run
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic bail();
        num_errors++;
        tally_and_finish();
    endtask
    // one apb transfer; read data and error land in rd and err
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int i;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        for (i = 0; i < 16; i++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (i == 16) bail();
    endtask
    // count edges until system reset ends
    task automatic wait_hi();
        for (n = 0; sys_rst_n !== 1'b1; n++) begin
            @(posedge clk);
            if (n > 4000) bail();
        end
    endtask
    // read the watchdog count after the last tick has settled
    task automatic cnt(input logic [8:0] e);
        repeat (4) @(posedge clk);
        apb(1'b0, ADDR_RESET_STATUS, 32'h0);
        `CHK(rd[16:8], e)
    endtask
    // ----
    // scenarios
    // ----
    task automatic s_regs();
        low_voltage_in <= 1'b1;
        apb(1'b0, ADDR_SYSTEM_OPTIONS, 32'h0);
        `CHK(rd, 32'h0000_0007)
        apb(1'b0, ADDR_RESET_STATUS, 32'h0);
        `CHK(rd, 32'h0000_0000)
        apb(1'b0, ADDR_POWER_MGMT, 32'h0);
        `CHK(rd[PWR_LV_FLAG_BIT], 1'b1)
        apb(1'b0, 12'h00C, 32'h0);
        `CHK({err, rd}, 33'h1_0000_0000)
        low_voltage_in <= 1'b0;
    endtask
    task automatic s_sync();
        for (int k = 0; k < 3; k++) begin
            illegal_address_detect <= (k == 0);
            illegal_opcode_detect <= (k == 1);
            debug_controller_reset <= (k == 2);
            @(posedge clk);
            illegal_address_detect <= 1'b0;
            illegal_opcode_detect <= 1'b0;
            debug_controller_reset <= 1'b0;
            repeat (3) @(posedge clk);
            `CHK(sys_rst_n, 1'b0)
            wait_hi();
            `CHK(n >= 137 && n <= 143, 1'b1)
            apb(1'b0, ADDR_RESET_STATUS, 32'h0);
            `CHK(rd[4:0], 5'h04 << k)
        end
    endtask
    // pin pulse during a synchronous reset takes over its timing
    task automatic s_mix();
        illegal_address_detect <= 1'b1;
        @(posedge clk);
        illegal_address_detect <= 1'b0;
        repeat (40) @(posedge clk);
        illegal_opcode_detect <= 1'b1;
        fork u_rst_partner.pin_low(4); join_none
        @(posedge clk);
        illegal_opcode_detect <= 1'b0;
        @(posedge clk);
        wait_hi();
        `CHK(n >= 144 && n <= 153, 1'b1)
        apb(1'b0, ADDR_RESET_STATUS, 32'h0);
        `CHK(rd[4:0], 5'h01)
        `CHK(sys_rst_n, 1'b1)
    endtask
    task automatic s_pins();
        fork u_rst_partner.pin_low(4); join_none
        repeat (2) @(posedge clk);
        `CHK(sys_rst_n, 1'b0)
        wait_hi();
        `CHK(n >= 144 && n <= 153, 1'b1)
        fork u_rst_partner.pin_low(200); join_none
        repeat (180) @(posedge clk);
        `CHK({sysclk_src_en, sys_rst_n}, 2'h0)
        repeat (21) @(posedge clk);
        for (n = 0; n < 40 && bus_clk_run !== 1'b1; n++) @(posedge clk);
        `CHK(n >= 17 && n <= 23, 1'b1)
        wait_hi();
        `CHK(n <= 11, 1'b1)
    endtask
    task automatic s_wdog();
        apb(1'b1, ADDR_SYSTEM_OPTIONS, 32'h3);
        u_rst_partner.ticks(5);
        cnt(9'h005);
        in_debug <= 1'b1;
        u_rst_partner.ticks(40);
        in_debug <= 1'b0;
        cnt(9'h005);
        apb(1'b1, ADDR_RESET_STATUS, 32'hA5);
        cnt(9'h000);
        u_rst_partner.ticks(3);
        in_stop <= 1'b1;
        u_rst_partner.ticks(2);
        in_stop <= 1'b0;
        u_rst_partner.ticks(2);
        cnt(9'h002);
        apb(1'b1, ADDR_SYSTEM_OPTIONS, 32'h7);
        u_rst_partner.ticks(29);
        cnt(9'h01F);
        u_rst_partner.ticks(1);
        repeat (8) @(posedge clk);
        `CHK(sys_rst_n, 1'b0)
        wait_hi();
        apb(1'b0, ADDR_RESET_STATUS, 32'h0);
        `CHK(rd[4:0], 5'h02)
        u_rst_partner.ticks(40);
        cnt(9'h028);
    endtask
    task automatic s_pin_off();
        apb(1'b1, ADDR_SYSTEM_OPTIONS, 32'h4);
        fork u_rst_partner.pin_low(20); join_none
        repeat (10) @(posedge clk);
        `CHK(sys_rst_n, 1'b1)
        repeat (12) @(posedge clk);
        apb(1'b0, ADDR_SYSTEM_OPTIONS, 32'h0);
        `CHK(rd, 32'h0000_0084)
        apb(1'b1, ADDR_SYSTEM_OPTIONS, 32'h3);
        apb(1'b0, ADDR_SYSTEM_OPTIONS, 32'h0);
        `CHK(rd, 32'h0000_0085)
        u_rst_partner.ticks(40);
        cnt(9'h000);
    endtask
    // reset, then the scenarios in turn
    initial begin
        clk = 1'b0;
        nrst = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        num_errors = 0;
        n_checks = 0;
        low_voltage_in = 1'b0;
        in_debug = 1'b0;
        in_stop = 1'b0;
        illegal_address_detect = 1'b0;
        illegal_opcode_detect = 1'b0;
        debug_controller_reset = 1'b0;
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        s_regs();
        s_sync();
        s_mix();
        s_pins();
        s_wdog();
        s_pin_off();
        tally_and_finish();
    end
endmodule
`default_nettype wire
